// ### bench/eth_reset_assertions.sv
// concurrent checks on the wires between core end and controller end
`timescale 1ns/1ps
module eth_reset_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic full_rst_n,
  input wire logic tx_rst_n,
  input wire logic rx_rst_n,
  input wire logic cfg_rst,
  input wire logic full_ack_n,
  input wire logic tx_ack_n,
  input wire logic rx_ack_n,
  input wire logic tx_lanes_stable,
  input wire logic rx_ready,
  input wire logic training_hold_request,
  input wire logic training_held_flag
);
  // ****************************************
  // core state is only defined after a full reset
  // ****************************************
  logic live;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      live <= 1'b0;
    else if (!full_ack_n)
      live <= 1'b1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || !live);

  a_full_ack_order: assert property ($fell(full_ack_n) |-> !tx_lanes_stable && !rx_ready)
    else $error("full ack asserted before statuses dropped");
  a_tx_ack_order: assert property ($fell(tx_ack_n) |-> !tx_lanes_stable)
    else $error("tx ack asserted while lanes stable");
  a_rx_ack_order: assert property ($fell(rx_ack_n) |-> !rx_ready)
    else $error("rx ack asserted while rx ready");
  a_tx_release_held: assert property ($rose(tx_rst_n) |-> !$past(tx_ack_n))
    else $error("tx reset released before ack");
  a_rx_release_held: assert property ($rose(rx_rst_n) |-> !$past(rx_ack_n))
    else $error("rx reset released before ack");
  a_full_release_ok: assert property ($rose(full_rst_n) |-> tx_rst_n && rx_rst_n && !$past(full_ack_n))
    else $error("full reset released out of order");
  a_tx_drop_bound: assert property ($fell(tx_rst_n) |-> ##[1:4] !tx_lanes_stable)
    else $error("lanes stable did not drop");
  a_rx_drop_bound: assert property ($fell(rx_rst_n) |-> ##[1:4] !rx_ready)
    else $error("rx ready did not drop");
  a_full_ack_bound: assert property ($fell(full_rst_n) |-> ##[2:20] !full_ack_n)
    else $error("full ack missing");
  a_release_sync: assert property ($rose(full_rst_n) |=> !full_ack_n)
    else $error("full release not synchronized");
  a_ack_release: assert property ($rose(full_rst_n) |-> ##[2:8] full_ack_n)
    else $error("full ack did not release");

  c_full: cover property ($fell(full_ack_n));
  c_tx: cover property ($fell(tx_ack_n));
  c_rx: cover property ($fell(rx_ack_n));
  c_cfg: cover property ($rose(cfg_rst) && training_hold_request);
endmodule

// ### bench/ethernet_core_reset_handshake_tb.sv
// self-checking bench for both reset handshake ends
`timescale 1ns/1ps
module ethernet_core_reset_handshake_tb;
  import eth_reset_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       cfg_clk_stable = 1'b0;
  logic       training_on = 1'b0;
  logic [3:0] req = 4'h0;
  logic       autoneg = 1'b0;
  logic       core_cfg_req = 1'b0;
  logic       hard_wr = 1'b0;
  logic [7:0] hard_data = 8'h00;
  logic       cfg_ack, tx_mac_ready, busy;
  logic [7:0] hard_ctrl, soft_ctrl, hard_exp;
  int         miscompares = 0;
  int         n_tests = 0;
  int         k;
  logic       cadence = 1'b0;
  logic       cadence_live = 1'b0;

  always #10 clk_i = ~clk_i;

  // stand-in for client cadence and marker insertion ahead of lanes stable
  always @(posedge clk_i)
  begin
    cadence <= ~cadence;
    if (cadence)
      cadence_live <= 1'b1;
  end

  eth_reset_if link_if ();
  eth_core_reset #(.ACK_CYCLES(ACK_DELAY), .READY_CYCLES(READY_DELAY)) i_eth_core_reset (
    .clk_i(clk_i), .link(link_if), .autoneg_and_training_i(autoneg),
    .cfg_req_i(core_cfg_req), .hard_ctrl_wr_i(hard_wr), .hard_ctrl_data_i(hard_data),
    .cfg_ack_o(cfg_ack), .hard_ctrl_o(hard_ctrl), .soft_ctrl_o(soft_ctrl),
    .tx_mac_ready_o(tx_mac_ready));
  eth_reset_ctrl #(.HOLD_CYCLES(CFG_HOLD)) i_eth_reset_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .link(link_if), .cfg_clk_stable_i(cfg_clk_stable),
    .training_on_i(training_on), .full_req_i(req[0]), .tx_req_i(req[1]),
    .rx_req_i(req[2]), .cfg_req_i(req[3]), .busy_o(busy));
  eth_reset_assertions i_eth_reset_assertions (
    .clk_i(clk_i), .rst_i(rst_i), .full_rst_n(link_if.full_rst_n),
    .tx_rst_n(link_if.tx_rst_n), .rx_rst_n(link_if.rx_rst_n), .cfg_rst(link_if.cfg_rst),
    .full_ack_n(link_if.full_ack_n), .tx_ack_n(link_if.tx_ack_n),
    .rx_ack_n(link_if.rx_ack_n), .tx_lanes_stable(link_if.tx_lanes_stable),
    .rx_ready(link_if.rx_ready), .training_hold_request(link_if.training_hold_request),
    .training_held_flag(link_if.training_held_flag));

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  function automatic logic ack_of(input int s);
    return (s == 0) ? link_if.full_ack_n : (s == 1) ? link_if.tx_ack_n : link_if.rx_ack_n;
  endfunction

  // statuses {tx, rx} expected while a reset kind is acknowledged
  function automatic logic [7:0] exp_status(input int s);
    return (s == 0) ? 8'h00 : (s == 1) ? 8'h01 : 8'h02;
  endfunction

  // kind 0 full, 1 tx, 2 rx, 3 configuration
  task automatic run_seq(input int s, input logic hold_on);
    int n;
    int cnt;
    int top;
    n = 0;
    cnt = 0;
    top = 0;
    @(posedge clk_i);
    req[s] <= 1'b1;
    training_on <= hold_on | 1'($urandom_range(1));
    core_cfg_req <= (s == 3);
    if (s < 3)
    begin
      while (ack_of(s) !== 1'b0 && n < 60)
      begin
        @(negedge clk_i);
        n++;
      end
      check("ack", 8'h00, {7'h0, ack_of(s)});
      check("status", exp_status(s), {6'h0, link_if.tx_lanes_stable, link_if.rx_ready});
      if (s == 2)
        check("tx mac ready", 8'h00, {7'h0, tx_mac_ready});
      @(posedge clk_i) req[s] <= 1'b0;
    end
    else
    begin
      while (busy !== 1'b1 && n < 60)
      begin
        @(negedge clk_i);
        n++;
      end
      @(posedge clk_i) req[s] <= 1'b0;
      while (busy === 1'b1 && n < 300)
      begin
        @(negedge clk_i);
        n++;
        cnt = (link_if.cfg_rst === 1'b1) ? cnt + 1 : 0;
        top = (cnt > top) ? cnt : top;
        if (cnt == 1 && training_on)
          check("held flag", 8'h01, {7'h0, link_if.training_held_flag});
        if (cnt == 4)
          check("cfg ack", 8'h00, {7'h0, cfg_ack});
        if (cnt == 4)
          check("soft ctrl", 8'h00, soft_ctrl);
      end
      check("cfg hold", 8'h01, {7'h0, top >= CFG_HOLD});
      repeat (4) @(negedge clk_i);
      check("cfg ack", 8'h01, {7'h0, cfg_ack});
      check("soft ctrl", hard_exp, soft_ctrl);
      @(posedge clk_i) core_cfg_req <= 1'b0;
    end
    n = 0;
    while ((busy !== 1'b0 || link_if.tx_lanes_stable !== 1'b1 || link_if.rx_ready !== 1'b1)
           && n < 200)
    begin
      @(negedge clk_i);
      n++;
    end
    check("acks", 8'h07, {5'h0, link_if.full_ack_n, link_if.tx_ack_n, link_if.rx_ack_n});
    check("statuses", 8'h03, {6'h0, link_if.tx_lanes_stable, link_if.rx_ready});
    check("hard ctrl", hard_exp, hard_ctrl);
    check("cadence", 8'h01, {7'h0, cadence_live});
    @(negedge clk_i);
    check("tx mac ready", 8'h01, {7'h0, tx_mac_ready});
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin
    void'($urandom(24));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (20) @(negedge clk_i);
    check("cfg rst", 8'h01, {7'h0, link_if.cfg_rst});
    @(posedge clk_i) cfg_clk_stable <= 1'b1;
    repeat (40) @(negedge clk_i);
    check("cfg rst", 8'h00, {7'h0, link_if.cfg_rst});
    @(posedge clk_i);
    hard_wr <= 1'b1;
    hard_data <= 8'($urandom);
    @(posedge clk_i) hard_wr <= 1'b0;
    hard_exp = hard_data;
    for (int t = 0; t < 18; t++)
    begin
      k = (t < 4) ? t : int'($urandom_range(3));
      run_seq(k, t == 3);
      $display("test %0d kind %0d done", t, k);
    end
    @(posedge clk_i) autoneg <= 1'b1;
    repeat (6) @(negedge clk_i);
    check("statuses", 8'h00, {6'h0, link_if.tx_lanes_stable, link_if.rx_ready});
    @(posedge clk_i) autoneg <= 1'b0;
    repeat (30) @(negedge clk_i);
    check("statuses", 8'h03, {6'h0, link_if.tx_lanes_stable, link_if.rx_ready});
    $display("test autoneg done");
    complete_run();
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    $display("[ERR] watchdog expected finish seen hang");
    complete_run();
  end
endmodule

// ### hdl/eth_core_reset.sv
// core end: reset synchronizers, acknowledges and ready statuses
`timescale 1ns/1ps
module eth_core_reset #(
  parameter int unsigned ACK_CYCLES   = eth_reset_pkg::ACK_DELAY,
  parameter int unsigned READY_CYCLES = eth_reset_pkg::READY_DELAY
) (
  input  wire logic  clk_i,
  eth_reset_if.core  link,
  input  wire logic  autoneg_and_training_i,
  input  wire logic  cfg_req_i,
  input  wire logic  hard_ctrl_wr_i,
  input  wire logic  [7:0] hard_ctrl_data_i,
  output logic       cfg_ack_o,
  output logic       [7:0] hard_ctrl_o,
  output logic       [7:0] soft_ctrl_o,
  output logic       tx_mac_ready_o
);
  import eth_reset_pkg::*;

  // ************************************************************
  // parameter checks
  // ************************************************************
  if (ACK_CYCLES < 1 || ACK_CYCLES > 2**CNT_W - 1)
  begin : g_bad_ack
    $error("ack cycle count out of range");
  end
  if (READY_CYCLES < 1 || READY_CYCLES > 2**CNT_W - 1)
  begin : g_bad_ready
    $error("ready cycle count out of range");
  end

  // ************************************************************
  // reset synchronizers
  // ************************************************************
  logic [1:0] full_sync;
  logic [1:0] tx_sync;
  logic [1:0] rx_sync;
  logic [1:0] cfg_sync;
  wire  full_in = ~link.full_rst_n;
  wire  tx_in   = ~link.tx_rst_n;
  wire  rx_in   = ~link.rx_rst_n;
  wire  cfg_in  = link.cfg_rst;

  always_ff @(posedge clk_i or posedge full_in)
  begin
    if (full_in)
      full_sync <= SYNC_SET;
    else
      full_sync <= {full_sync[0], 1'b0};
  end

  always_ff @(posedge clk_i or posedge tx_in)
  begin
    if (tx_in)
      tx_sync <= SYNC_SET;
    else
      tx_sync <= {tx_sync[0], 1'b0};
  end

  always_ff @(posedge clk_i or posedge rx_in)
  begin
    if (rx_in)
      rx_sync <= SYNC_SET;
    else
      rx_sync <= {rx_sync[0], 1'b0};
  end

  always_ff @(posedge clk_i or posedge cfg_in)
  begin
    if (cfg_in)
      cfg_sync <= SYNC_SET;
    else
      cfg_sync <= {cfg_sync[0], 1'b0};
  end

  wire full_r = full_sync[1];
  wire tx_r   = tx_sync[1] | full_r;
  wire rx_r   = rx_sync[1] | full_r;
  wire cfg_r  = cfg_sync[1];

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic             full_ack_n;
    logic             tx_ack_n;
    logic             rx_ack_n;
    logic             tx_stable;
    logic             rx_ready;
    logic [CNT_W-1:0] tx_cnt;
    logic [CNT_W-1:0] rx_cnt;
    logic [CNT_W-1:0] full_cnt;
    logic [7:0]       soft_ctrl;
    logic             held;
    logic             cfg_ack;
    logic             mac_ready;
    logic             tx_seen;
    logic             rx_seen;
    logic             full_seen;
    logic [7:0]       hard_ctrl;
  } core_t;

  core_t cur;
  core_t next_cur;

  // ************************************************************
  // helpers
  // ************************************************************

  function automatic logic [CNT_W-1:0] count_up(input logic [CNT_W-1:0] c,
                                                 input int unsigned lim);
    count_up = (c == CNT_W'(lim)) ? c : c + CNT_ONE;
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    next_cur = cur;
    // ********************************************************
    // transmit path: status falls first, acknowledge after the delay
    // ********************************************************
    if (tx_r)
    begin
      next_cur.tx_stable = 1'b0;
      // first cycle of a reset starts the count from a known value
      next_cur.tx_cnt    = (!cur.tx_seen || cur.tx_stable) ? CNT_ZERO
                           : count_up(cur.tx_cnt, ACK_CYCLES);
      if (!cur.tx_stable && cur.tx_cnt == CNT_W'(ACK_CYCLES))
        next_cur.tx_ack_n = 1'b0;
    end
    else
    begin
      next_cur.tx_ack_n = 1'b1;
      next_cur.tx_cnt   = (cur.tx_ack_n) ? count_up(cur.tx_cnt, READY_CYCLES) : CNT_ZERO;
      next_cur.tx_stable = cur.tx_ack_n && cur.tx_cnt == CNT_W'(READY_CYCLES)
                           && !autoneg_and_training_i;
    end
    // ********************************************************
    // receive path: status falls first, acknowledge after the delay
    // ********************************************************
    if (rx_r)
    begin
      next_cur.rx_ready = 1'b0;
      next_cur.rx_cnt   = (!cur.rx_seen || cur.rx_ready) ? CNT_ZERO
                          : count_up(cur.rx_cnt, ACK_CYCLES);
      if (!cur.rx_ready && cur.rx_cnt == CNT_W'(ACK_CYCLES))
        next_cur.rx_ack_n = 1'b0;
    end
    else
    begin
      next_cur.rx_ack_n = 1'b1;
      next_cur.rx_cnt   = (cur.rx_ack_n) ? count_up(cur.rx_cnt, READY_CYCLES) : CNT_ZERO;
      next_cur.rx_ready = cur.rx_ack_n && cur.rx_cnt == CNT_W'(READY_CYCLES)
                          && !autoneg_and_training_i;
    end
    // ********************************************************
    // full acknowledge waits for both statuses to be down
    // ********************************************************
    if (full_r)
    begin
      next_cur.full_cnt = (!cur.full_seen || cur.tx_stable || cur.rx_ready) ? CNT_ZERO
                          : count_up(cur.full_cnt, ACK_CYCLES);
      if (cur.full_cnt == CNT_W'(ACK_CYCLES))
        next_cur.full_ack_n = 1'b0;
    end
    else
    begin
      next_cur.full_cnt   = CNT_ZERO;
      next_cur.full_ack_n = 1'b1;
    end
    next_cur.mac_ready = cur.tx_stable && !rx_r;
    next_cur.tx_seen   = tx_r;
    next_cur.rx_seen   = rx_r;
    next_cur.full_seen = full_r;
    // ********************************************************
    // configuration domain
    // ********************************************************
    if (cfg_r)
    begin
      next_cur.soft_ctrl = '0;
      next_cur.held      = 1'b0;
      next_cur.cfg_ack   = 1'b0;
    end
    else
    begin
      next_cur.held    = link.training_hold_request;
      next_cur.cfg_ack = cfg_req_i;
      if (cfg_req_i)
        next_cur.soft_ctrl = hard_ctrl_data_i;
    end
    // hard control register is cleared by no reset
    if (hard_ctrl_wr_i && !cfg_r)
      next_cur.hard_ctrl = hard_ctrl_data_i;
  end

  // ************************************************************
  // state register, cleared only through the link resets
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    cur <= next_cur;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign link.full_ack_n         = cur.full_ack_n;
  assign link.tx_ack_n           = cur.tx_ack_n;
  assign link.rx_ack_n           = cur.rx_ack_n;
  assign link.tx_lanes_stable    = cur.tx_stable;
  assign link.rx_ready           = cur.rx_ready;
  assign link.training_held_flag = cur.held;
  assign cfg_ack_o      = cur.cfg_ack;
  assign hard_ctrl_o    = cur.hard_ctrl;
  assign soft_ctrl_o    = cur.soft_ctrl;
  assign tx_mac_ready_o = cur.mac_ready;
endmodule

// ### hdl/eth_reset_ctrl.sv
// controller end: drives the resets and waits on acknowledges
`timescale 1ns/1ps
module eth_reset_ctrl #(
  parameter int unsigned HOLD_CYCLES = eth_reset_pkg::CFG_HOLD
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  eth_reset_if.ctrl link,
  input  wire logic cfg_clk_stable_i,
  input  wire logic training_on_i,
  input  wire logic full_req_i,
  input  wire logic tx_req_i,
  input  wire logic rx_req_i,
  input  wire logic cfg_req_i,
  output logic      busy_o
);
  import eth_reset_pkg::*;

  if (HOLD_CYCLES < 1 || HOLD_CYCLES > 2**CNT_W - 1)
  begin : g_bad_hold
    $error("hold count out of range");
  end

  typedef struct packed {
    ctl_state_t       st;
    logic             full_n;
    logic             tx_n;
    logic             rx_n;
    logic             cfg;
    logic             hold_req;
    logic [CNT_W-1:0] cnt;
    logic             busy;
  } ctl_t;

  ctl_t cur;
  ctl_t next_cur;

  always_comb
  begin
    next_cur = cur;
    unique case (cur.st)
      CTL_INIT:
      begin
        next_cur.cfg = 1'b1;
        if (cfg_clk_stable_i && cur.cnt != CNT_W'(HOLD_CYCLES))
          next_cur.cnt = cur.cnt + CNT_ONE;
        if (cfg_clk_stable_i && cur.cnt == CNT_W'(HOLD_CYCLES))
        begin
          next_cur.cfg  = 1'b0;
          next_cur.st   = CTL_RUN;
          next_cur.busy = 1'b0;
        end
      end
      CTL_RUN:
      begin
        next_cur.cnt = CNT_ZERO;
        if (full_req_i)
        begin
          next_cur.full_n = 1'b0;
          next_cur.st = CTL_WAIT_ACK;
          next_cur.busy = 1'b1;
        end
        else if (tx_req_i)
        begin
          next_cur.tx_n = 1'b0;
          next_cur.st = CTL_WAIT_ACK;
          next_cur.busy = 1'b1;
        end
        else if (rx_req_i)
        begin
          next_cur.rx_n = 1'b0;
          next_cur.st = CTL_WAIT_ACK;
          next_cur.busy = 1'b1;
        end
        else if (cfg_req_i)
        begin
          next_cur.hold_req = training_on_i;
          next_cur.st = CTL_CFG;
          next_cur.busy = 1'b1;
        end
      end
      CTL_WAIT_ACK:
      begin
        if (!cur.full_n && !link.full_ack_n)
        begin
          next_cur.full_n = 1'b1;
          next_cur.st = CTL_FULL_REL;
        end
        if (!cur.tx_n && !link.tx_ack_n)
        begin
          next_cur.tx_n = 1'b1;
          next_cur.st = CTL_FULL_REL;
        end
        if (!cur.rx_n && !link.rx_ack_n)
        begin
          next_cur.rx_n = 1'b1;
          next_cur.st = CTL_FULL_REL;
        end
      end
      CTL_FULL_REL:
      begin
        if (link.full_ack_n && link.tx_ack_n && link.rx_ack_n)
        begin
          next_cur.st = CTL_RUN;
          next_cur.busy = 1'b0;
        end
      end
      CTL_CFG:
      begin
        // once raised, the configuration reset runs its whole hold time
        if (!cur.hold_req || link.training_held_flag || cur.cfg)
        begin
          next_cur.cfg = 1'b1;
          next_cur.cnt = cur.cnt + CNT_ONE;
          if (cur.cnt == CNT_W'(HOLD_CYCLES))
          begin
            next_cur.cfg = 1'b0;
            next_cur.hold_req = 1'b0;
            next_cur.st = CTL_RUN;
            next_cur.busy = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cur.st       <= CTL_INIT;
      cur.full_n   <= 1'b1;
      cur.tx_n     <= 1'b1;
      cur.rx_n     <= 1'b1;
      cur.cfg      <= 1'b1;
      cur.hold_req <= 1'b0;
      cur.cnt      <= CNT_ZERO;
      cur.busy     <= 1'b1;
    end
    else
      cur <= next_cur;
  end

  assign link.full_rst_n            = cur.full_n;
  assign link.tx_rst_n              = cur.tx_n;
  assign link.rx_rst_n              = cur.rx_n;
  assign link.cfg_rst               = cur.cfg;
  assign link.training_hold_request = cur.hold_req;
  assign busy_o                     = cur.busy;
endmodule

// ### hdl/eth_reset_if.sv
// interface joining the core and the reset controller
`timescale 1ns/1ps
interface eth_reset_if;
  logic full_rst_n;
  logic tx_rst_n;
  logic rx_rst_n;
  logic cfg_rst;
  logic full_ack_n;
  logic tx_ack_n;
  logic rx_ack_n;
  logic tx_lanes_stable;
  logic rx_ready;
  logic training_hold_request;
  logic training_held_flag;

  modport core (
    input  full_rst_n, tx_rst_n, rx_rst_n, cfg_rst, training_hold_request,
    output full_ack_n, tx_ack_n, rx_ack_n, tx_lanes_stable, rx_ready, training_held_flag
  );
  modport ctrl (
    output full_rst_n, tx_rst_n, rx_rst_n, cfg_rst, training_hold_request,
    input  full_ack_n, tx_ack_n, rx_ack_n, tx_lanes_stable, rx_ready, training_held_flag
  );
endinterface

// ### hdl/eth_reset_pkg.sv
// constants and types shared by the reset handshake ends
// How it works
// - all resets enter asynchronously, synchronized before use
// - full reset holds both paths, then acknowledges
// - transmit reset held until transmit acknowledge
// - receive reset held until receive acknowledge
// - configuration reset clears the configuration domain
// - controller asserts configuration reset until clock stable
// - pause training and wait before configuration reset
// - acknowledges active low; full held until acknowledged
// - lanes stable up when transmit usable, else down
// - receive ready up when receive usable, else down
// - full released only after path resets; acknowledge drops
// - path acknowledges also drop, order not guaranteed
// - both statuses rise once fully out of reset
// - transmit reset drops status, then acknowledges
// - receive reset drops status, then acknowledges
// - full reset drops both statuses, then acknowledges
// - full reset needed at startup; core counters and statuses stay undefined until the first full reset
// - cadence toggling before lanes stable rises
// - alignment markers inserted before lanes stable rises
// - hold configuration reset several clock cycles
// - configuration accesses served only outside configuration reset
// - receive MAC in reset keeps transmit ready low
// - no reset clears the hard control registers
package eth_reset_pkg;
  localparam int unsigned SYNC_STAGES    = 2;
  localparam int unsigned ACK_DELAY      = 4;
  localparam int unsigned READY_DELAY    = 8;
  localparam int unsigned CFG_HOLD       = 8;
  localparam int unsigned CNT_W          = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE   = 8'h01;
  localparam logic [1:0] SYNC_CLEAR      = 2'h0;
  localparam logic [1:0] SYNC_SET        = 2'h3;

  typedef enum logic [4:0] {
    CTL_INIT     = 5'h01,
    CTL_FULL_REL = 5'h02,
    CTL_RUN      = 5'h04,
    CTL_WAIT_ACK = 5'h08,
    CTL_CFG      = 5'h10
  } ctl_state_t;
endpackage
